// ===== dv/i2cee_master_model.sv
// Two-wire bus master model that drives the link and reports each byte it clocked.
`timescale 1ns/1ps
`default_nettype none
module i2cee_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic obs_v_out,
  output logic [8:0] obs_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    obs_v_out = 1'b0;
    obs_out = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves two cycles before the rise, so the slave never sees it beside a clock edge.
  task automatic bit_io(input logic b, output logic s);
    wt(3);
    sda_out <= b;
    wt(2);
    scl_out <= 1'b1;
    wt(2);
    s = sda_in;
    wt(1);
    scl_out <= 1'b0;
  endtask
  task automatic start();
    wt(2);
    sda_out <= 1'b1;
    wt(3);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_out <= 1'b0;
    wt(3);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b1;
    wt(4);
  endtask
  // Sends eight bits MSB first, then the ninth bit; what the wire showed is reported.
  task automatic xfer(input logic [7:0] d, input logic ack_in);
    logic [7:0] g;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], g[i]);
    end
    bit_io(ack_in, a);
    obs_out <= {a, g};
    obs_v_out <= 1'b1;
    wt(1);
    obs_v_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_i2c_serial_eeprom_slave.sv
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_serial_eeprom_slave;
  import i2cee_pkg::*;
  localparam int PROG = 300;
  localparam int LOAD = 200;
  // Arbitrary device type code for this bench.
  localparam logic [3:0] DEV = 4'h5;
  logic clk_in, resetn_in, scl, sda_m, sda_out, sda_oe_n, reg_wr, reg_rd, busy, obs_v, rd_q;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [8:0] obs;
  logic [8:0] exp_q[$];
  logic [7:0] mem [0:511];
  logic [2:0] code;
  int bad_count, checks_done, cyc, t0, seed;
  wire logic sda_w;
  // The line has a pull-up: released by both parties it reads high.
  assign sda_w = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  i2cee_master_model u_mst (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m),
    .obs_v_out(obs_v), .obs_out(obs));
  i2cee_slave #(.DEV_TYPE(DEV), .PROG_CYCLES_P(PROG), .LOAD_CYCLES_P(LOAD)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .busy_out(busy));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Results are compared in the order they were noted.
  always @(posedge clk_in) begin
    // Counted by non-blocking update so every reader at an edge sees the same value.
    cyc <= cyc + 1;
    if (obs_v) chk("link", {7'h00, exp_q.pop_front()}, {7'h00, obs});
    if (rd_q) chk("reg", {7'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    rd_q <= reg_rd;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic byte_w(input logic [7:0] v, input logic ea);
    exp_q.push_back({ea, v});
    u_mst.xfer(v, 1'b1);
  endtask
  task automatic byte_r(input logic [7:0] e, input logic mack);
    exp_q.push_back({mack, e});
    u_mst.xfer(8'hff, mack);
  endtask
  task automatic hdr(input logic [3:0] t, input logic [2:0] c, input logic r, input logic ea);
    u_mst.start();
    byte_w({t, c, r}, ea);
  endtask
  task automatic set_addr(input logic [15:0] a);
    hdr(DEV, code, 1'b0, 1'b0);
    byte_w(a[15:8], 1'b0);
    byte_w(a[7:0], 1'b0);
  endtask
  task automatic wait_idle();
    while (busy && cyc < t0 + 2000) @(posedge clk_in);
  endtask
  task automatic end_write();
    u_mst.stop();
    t0 = cyc;
    repeat (2) @(posedge clk_in);
    chk("busy", 16'h1, {15'h0, busy});
    hdr(DEV, code, 1'b0, 1'b1);
    u_mst.stop();
    wait_idle();
    chk("prog_ok", 16'h1, {15'h0, (cyc - t0 >= PROG - 12) && (cyc - t0 <= PROG)});
  endtask
  initial begin
    resetn_in = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_q = 1'b0;
    seed = 88;
    code = 3'h0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reg_read(REG_KEY, KEY_RESET);
    reg_read(REG_STATUS, 8'h02);
    hdr(DEV, 3'h0, 1'b0, 1'b1);
    u_mst.stop();
    reg_write(4'hc, 8'h5a);
    reg_read(4'hc, 8'h00);
    repeat (LOAD) @(posedge clk_in);
    reg_read(REG_STATUS, 8'h00);
    hdr(4'h6, 3'h0, 1'b0, 1'b1);
    for (int c = 1; c < 8; c++) begin
      hdr(DEV, 3'(c), 1'b0, 1'b1);
    end
    u_mst.stop();
    d = 8'($random(seed));
    set_addr(16'h0000);
    byte_w(d, 1'b0);
    mem[0] = d;
    end_write();
    set_addr(16'h01fe);
    for (int i = 0; i < 10; i++) begin
      d = 8'($random(seed));
      byte_w(d, 1'b0);
      mem[{6'h3f, 3'(6 + i)}] = d;
    end
    end_write();
    set_addr(16'h01fe);
    hdr(DEV, code, 1'b1, 1'b0);
    byte_r(mem[9'h1fe], 1'b0);
    byte_r(mem[9'h1ff], 1'b0);
    byte_r(mem[0], 1'b1);
    byte_r(8'hff, 1'b1);
    u_mst.stop();
    set_addr(16'h01f8);
    hdr(DEV, code, 1'b1, 1'b0);
    byte_r(mem[9'h1f8], 1'b1);
    u_mst.stop();
    reg_write(REG_KEY, KEY_UNLOCK);
    reg_read(REG_KEY, KEY_UNLOCK);
    set_addr(CODE_LOC);
    byte_w(8'h07, 1'b0);
    u_mst.stop();
    t0 = cyc;
    repeat (4) @(posedge clk_in);
    wait_idle();
    resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (LOAD + 8) @(posedge clk_in);
    reg_read(REG_KEY, KEY_RESET);
    // The stored code is a flop that resets to its default, so reset undoes the change.
    reg_read(REG_STATUS, 8'h00);
    code = 3'h7;
    hdr(DEV, code, 1'b0, 1'b1);
    code = 3'h0;
    set_addr(16'h0000);
    hdr(DEV, code, 1'b1, 1'b0);
    byte_r(mem[0], 1'b1);
    u_mst.stop();
    repeat (20) @(posedge clk_in);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== rtl/i2cee_pkg.sv
// Constants for the two-wire serial EEPROM slave and its register port.
// Behaviour
// - Sample data on clock rise, drive on fall.
// - Data falling with clock high starts transaction.
// - Data rising with clock high stops transaction.
// - Stop after a read returns to standby.
// - Stop after write runs timed program cycle.
// - Byte units; low acknowledge after written bytes.
// - Release after read byte; low ack continues.
// - No ack then stop ends the read.
// - No ack, no stop: stay released, silent.
// - Header is seven address bits plus direction.
// - Address is type code then slave code.
// - Select only when slave code matches reference.
// - Mismatch returns to standby without responding.
// - Direction bit zero writes, one reads.
// - Slave code copied to reference after reset.
// - Stored code defaults zero, accepts zero to seven.
// - Memory address two bytes, upper first, MSB first.
// - Write data bytes arrive MSB first.
// - Code change needs key unlock value first.
// - 512 bytes; single or eight-byte page writes.
// - Page write advances low three bits, wrapping.
// - Header during program cycle is not acknowledged.
// - Sequential read increments, wraps after last address.
package i2cee_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int PROG_TIME_US = 10000;
  localparam int LOAD_TIME_US = 10000;
  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_KHZ / 1000);
  localparam int LOAD_CYCLES = LOAD_TIME_US * (CLK_KHZ / 1000);
  localparam int CNT_W = 20;
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 8;
  localparam logic [3:0] REG_KEY = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [7:0] KEY_RESET = 8'hff;
  localparam logic [7:0] KEY_UNLOCK = 8'h5f;
  localparam logic [15:0] CODE_LOC = 16'hff09;
  localparam logic [7:0] CODE_MAX = 8'h07;
  localparam logic [2:0] CODE_DEFAULT = 3'h0;
  localparam logic [8:0] MEM_LAST = 9'h1ff;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] IDX_HDR = 2'h0;
  localparam logic [1:0] IDX_AHI = 2'h1;
  localparam logic [1:0] IDX_ALO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic [1:0] CNT_NONE = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_MANY = 2'h2;
  localparam int ST_BUSY = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_REF_LO = 2;
  localparam int ST_REF_HI = 4;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RECV = 7'h02,
    ST_ACKO = 7'h04,
    ST_SEND = 7'h08,
    ST_ACKI = 7'h10,
    ST_RNEXT = 7'h20,
    ST_IGNORE = 7'h40
  } i2cee_state_e;
endpackage

// ===== rtl/i2cee_slave.sv
// Two-wire serial EEPROM slave with its key and status register port.
`timescale 1ns/1ps
`default_nettype none
module i2cee_slave #(
  // Arbitrary device type code; set per system.
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int PROG_CYCLES_P = i2cee_pkg::PROG_CYCLES,
  parameter int LOAD_CYCLES_P = i2cee_pkg::LOAD_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic busy_out
);
  import i2cee_pkg::*;

  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] PAGE_CNT = CNT_W'(PAGE_BYTES);

  logic rst_n_s1_q;
  logic rst_n_q;
  logic scl_s1_q, scl_s_q, scl_d_q;
  logic sda_s1_q, sda_s_q, sda_d_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  i2cee_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic [7:0] rx_byte;
  logic [7:0] tx_q;
  logic [1:0] byte_idx_q;
  logic [1:0] data_cnt_q;
  logic rd_mode_q;
  logic wr_sel_q;
  logic [15:0] addr_q;
  logic [15:0] wadr_q;
  logic [PAGE_BYTES-1:0] pvalid_q;
  logic sda_oe_n_q;
  logic hdr_match;
  logic data_wr;
  logic [7:0] key_q;
  logic [7:0] rdata_q;
  logic loading_q;
  logic [CNT_W-1:0] load_cnt_q;
  logic [2:0] ref_q;
  logic [2:0] stored_code_q;
  logic busy_q;
  logic [CNT_W-1:0] prog_cnt_q;
  logic code_prog_q;
  logic code_wr;
  logic commit;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];

  // Reset is released through two flops so every register reset by rst_n_q leaves reset on the same edge.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_n_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_n_s1_q <= 1'b1;
      rst_n_q <= rst_n_s1_q;
    end
  end

  // Bus lines idle high, so the synchronisers reset high to avoid a false start.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_s1_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s_q <= scl_s1_q;
      scl_d_q <= scl_s_q;
      sda_s1_q <= sda_in;
      sda_s_q <= sda_s1_q;
      sda_d_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_d_q;
  assign scl_fall = !scl_s_q && scl_d_q;
  assign start_ev = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
  assign stop_ev = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;
  assign rx_byte = {sh_q[6:0], sda_s_q};
  assign hdr_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3:1] == ref_q)
                     && !busy_q && !loading_q;
  assign data_wr = (state_q == ST_RECV) && scl_rise && (bit_cnt_q == BIT_LAST)
                   && (byte_idx_q == IDX_DATA);
  assign code_wr = wr_sel_q && (data_cnt_q == CNT_ONE) && (wadr_q == CODE_LOC)
                   && (key_q == KEY_UNLOCK) && (pbuf[wadr_q[2:0]] <= CODE_MAX);
  assign commit = busy_q && (prog_cnt_q < PAGE_CNT) && !code_prog_q;
  assign sda_out = 1'b0;
  assign sda_oe_n_out = sda_oe_n_q;
  assign reg_rdata_out = rdata_q;
  assign busy_out = busy_q;

  // Bus protocol engine: bits are taken on clock rise and driven on clock fall.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      byte_idx_q <= IDX_HDR;
      data_cnt_q <= CNT_NONE;
      rd_mode_q <= 1'b0;
      wr_sel_q <= 1'b0;
      addr_q <= 16'h0000;
      wadr_q <= 16'h0000;
      pvalid_q <= '0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
      rd_mode_q <= 1'b0;
      wr_sel_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= ST_RECV;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= IDX_HDR;
      data_cnt_q <= CNT_NONE;
      rd_mode_q <= 1'b0;
      wr_sel_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      if (!busy_q) begin
        pvalid_q <= '0;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe_n_q <= 1'b1;
        end
        ST_RECV: begin
          if (scl_rise && bit_cnt_q <= BIT_LAST) begin
            sh_q <= rx_byte;
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            if (bit_cnt_q == BIT_LAST) begin
              case (byte_idx_q)
                IDX_HDR: begin
                  if (!hdr_match) begin
                    state_q <= ST_IGNORE;
                  end
                  rd_mode_q <= rx_byte[0];
                  wr_sel_q <= hdr_match && !rx_byte[0];
                  byte_idx_q <= IDX_AHI;
                end
                IDX_AHI: begin
                  addr_q[15:8] <= rx_byte;
                  byte_idx_q <= IDX_ALO;
                end
                IDX_ALO: begin
                  addr_q[7:0] <= rx_byte;
                  wadr_q <= {addr_q[15:8], rx_byte};
                  byte_idx_q <= IDX_DATA;
                end
                default: begin
                  pvalid_q[addr_q[2:0]] <= 1'b1;
                  addr_q[2:0] <= 3'(addr_q[2:0] + 3'h1);
                  if (data_cnt_q != CNT_MANY) begin
                    data_cnt_q <= 2'(data_cnt_q + 2'h1);
                  end
                end
              endcase
            end
          end else if (scl_fall && bit_cnt_q == BIT_ACK) begin
            state_q <= ST_ACKO;
            sda_oe_n_q <= 1'b0;
            bit_cnt_q <= 4'h0;
          end
        end
        ST_ACKO: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rd_mode_q) begin
              tx_q <= mem[addr_q[8:0]];
              sda_oe_n_q <= mem[addr_q[8:0]][7];
              state_q <= ST_SEND;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q <= ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end else if (scl_fall && bit_cnt_q == BIT_ACK) begin
            sda_oe_n_q <= 1'b1;
            state_q <= ST_ACKI;
          end else if (scl_fall && bit_cnt_q != 4'h0) begin
            sda_oe_n_q <= tx_q[3'(BIT_LAST - bit_cnt_q)];
          end
        end
        ST_ACKI: begin
          if (scl_rise) begin
            if (sda_s_q) begin
              state_q <= ST_IGNORE;
            end else begin
              addr_q <= {7'h00, 9'(addr_q[8:0] + 9'h1)};
              state_q <= ST_RNEXT;
            end
          end
        end
        ST_RNEXT: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            tx_q <= mem[addr_q[8:0]];
            sda_oe_n_q <= mem[addr_q[8:0]][7];
            state_q <= ST_SEND;
          end
        end
        ST_IGNORE: begin
          sda_oe_n_q <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // The array and page buffer hold no reset; their contents stand for nonvolatile cells.
  always_ff @(posedge clk_in) begin
    if (data_wr) begin
      pbuf[addr_q[2:0]] <= rx_byte;
    end
    if (commit && pvalid_q[prog_cnt_q[2:0]]) begin
      mem[{addr_q[8:3], prog_cnt_q[2:0]}] <= pbuf[prog_cnt_q[2:0]];
    end
  end

  // Timed program cycle; for a memory write, page entries are copied during its first cycles.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
      code_prog_q <= 1'b0;
      stored_code_q <= CODE_DEFAULT;
    end else if (busy_q) begin
      prog_cnt_q <= CNT_W'(prog_cnt_q + 1'b1);
      if (prog_cnt_q == PROG_LAST) begin
        busy_q <= 1'b0;
      end
    end else if (stop_ev && wr_sel_q && data_cnt_q != CNT_NONE) begin
      busy_q <= 1'b1;
      prog_cnt_q <= '0;
      code_prog_q <= code_wr;
      if (code_wr) begin
        stored_code_q <= pbuf[wadr_q[2:0]][2:0];
      end
    end
  end

  // Reference code is loaded once after reset; the stored code itself resets to its default.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loading_q <= 1'b1;
      load_cnt_q <= '0;
      ref_q <= CODE_DEFAULT;
    end else if (loading_q) begin
      load_cnt_q <= CNT_W'(load_cnt_q + 1'b1);
      if (load_cnt_q == LOAD_LAST) begin
        loading_q <= 1'b0;
        ref_q <= stored_code_q;
      end
    end
  end

  // Register port: read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_q <= KEY_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == REG_KEY) begin
        key_q <= reg_wdata_in;
      end
      rdata_q <= 8'h00;
      if (reg_rd_in) begin
        case (reg_addr_in)
          REG_KEY: rdata_q <= key_q;
          REG_STATUS: begin
            rdata_q[ST_BUSY] <= busy_q;
            rdata_q[ST_LOAD] <= loading_q;
            rdata_q[ST_REF_HI:ST_REF_LO] <= ref_q;
          end
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_q);

  sequence s_nack;
    (state_q == ST_ACKI) && scl_rise && sda_s_q;
  endsequence

  sequence s_ack_last;
    (state_q == ST_ACKI) && scl_rise && !sda_s_q && (addr_q[8:0] == MEM_LAST);
  endsequence

  AST_DRIVE_ON_FALL: assert property (
    $changed(sda_oe_n_q) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
    else $error("data line changed away from a clock fall");
  AST_START_HDR: assert property (
    start_ev && !stop_ev |=> (state_q == ST_RECV) && (bit_cnt_q == 4'h0))
    else $error("start did not begin header reception");
  AST_STOP_IDLE: assert property (
    stop_ev |=> (state_q == ST_IDLE) && sda_oe_n_q)
    else $error("stop did not return to standby");
  AST_STOP_PROG: assert property (
    stop_ev && wr_sel_q && (data_cnt_q != CNT_NONE) && !busy_q |=> busy_q && (prog_cnt_q == '0))
    else $error("write stop did not start program cycle");
  AST_PROG_END: assert property (
    busy_q && (prog_cnt_q == PROG_LAST) |=> !busy_q)
    else $error("program cycle did not end on time");
  AST_ACK_LOW: assert property (
    (state_q == ST_ACKO) |-> !sda_oe_n_q)
    else $error("acknowledge not driven low");
  AST_READ_RELEASE: assert property (
    (state_q == ST_ACKI) |-> sda_oe_n_q)
    else $error("data line held after read byte");
  AST_NACK_SILENT: assert property (
    s_nack ##1 (!start_ev && !stop_ev) [*2] |-> (state_q == ST_IGNORE) && sda_oe_n_q)
    else $error("device kept sending after no acknowledge");
  AST_BUSY_NO_ACK: assert property (
    busy_q && (state_q == ST_RECV) && (byte_idx_q == IDX_HDR) && scl_rise
      && (bit_cnt_q == BIT_LAST) |=> (state_q == ST_IGNORE) && sda_oe_n_q)
    else $error("header acknowledged during program cycle");
  AST_LOAD_QUIET: assert property (
    loading_q |-> sda_oe_n_q && !wr_sel_q)
    else $error("device answered while code loading");
  AST_SEQ_WRAP: assert property (
    s_ack_last and (!stop_ev && !start_ev) |=> (addr_q[8:0] == 9'h000))
    else $error("sequential read did not wrap to zero");
endmodule
`default_nettype wire
